// *** rtl/cpu_program_register_file.v ***
/*
 Program register set: thirty-two general registers and the program
 counter, with two operand read ports, a base pointer read port for the
 short-format load and store, and one result write port per cycle.
 Assumes the pipeline presents read addresses two cycles ahead and one
 result write per cycle; reset is asynchronous, active low.
*/
// What this block does
// RULE1 - Thirty-two registers plus counter, all 32-bit
// RULE2 - Reads of zero register always return zero
// RULE3 - Writes to zero register are dropped
// RULE4 - Element pointer supplies short-format memory base
// RULE5 - Program counter tracks the executing instruction
// RULE6 - Two reads and one write every cycle
// RULE7 - 64 MB program, 4 GB data address reach
// RULE8 - Counter keeps 26 bits, bit 0 zero
`timescale 1ns/100ps
`include "prog_regs_defines.vh"

module cpu_program_register_file (
    input  wire                        clk_i,
    input  wire                        reset_n_i,
    input  wire [`REG_ADDR_WIDTH-1:0]  rs1_addr_i,
    input  wire [`REG_ADDR_WIDTH-1:0]  rs2_addr_i,
    input  wire                        wr_en_i,
    input  wire [`REG_ADDR_WIDTH-1:0]  wr_addr_i,
    input  wire [`REG_WIDTH-1:0]       wr_data_i,
    input  wire                        short_mem_i,
    input  wire                        pc_advance_i,
    input  wire                        pc_load_i,
    input  wire [`REG_WIDTH-1:0]       pc_target_i,
    output reg  [`REG_WIDTH-1:0]       rs1_data_o,
    output reg  [`REG_WIDTH-1:0]       rs2_data_o,
    output reg  [`REG_WIDTH-1:0]       base_addr_o,
    output reg                         base_valid_o,
    output reg  [`REG_WIDTH-1:0]       pc_o
);

    ////////////////////////////////////////////////////////////////////////
    wire                        wr_ok;
    wire [`REG_WIDTH-1:0]       arr_a;
    wire [`REG_WIDTH-1:0]       arr_b;
    wire [`REG_WIDTH-1:0]       arr_c;
    reg                         zero_a_ff;
    reg                         zero_b_ff;
    reg                         fwd_a_ff;
    reg                         fwd_b_ff;
    reg                         fwd_c_ff;
    reg  [`REG_WIDTH-1:0]       fwd_data_ff;
    reg                         short_ff;
    reg  [`REG_WIDTH-1:0]       nxt_pc;
    reg  [`REG_WIDTH-1:0]       pc_sum;

    assign wr_ok = wr_en_i && (wr_addr_i != `ZERO_REG_NUM); // RULE3

    gpr_array u_array (
        .clk_i     (clk_i),
        .we_i      (wr_ok),
        .waddr_i   (wr_addr_i),
        .wdata_i   (wr_data_i),
        .raddr_a_i (rs1_addr_i),
        .raddr_b_i (rs2_addr_i),
        .raddr_c_i (`EP_REG_NUM),
        .rdata_a_o (arr_a),
        .rdata_b_o (arr_b),
        .rdata_c_o (arr_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // Same-cycle write is forwarded so a read in that same cycle sees the result
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            zero_a_ff   <= 1'b1;
            zero_b_ff   <= 1'b1;
            fwd_a_ff    <= 1'b0;
            fwd_b_ff    <= 1'b0;
            fwd_c_ff    <= 1'b0;
            fwd_data_ff <= 32'h00000000;
            short_ff    <= 1'b0;
        end else begin
            zero_a_ff   <= (rs1_addr_i == `ZERO_REG_NUM); // RULE2
            zero_b_ff   <= (rs2_addr_i == `ZERO_REG_NUM); // RULE2
            fwd_a_ff    <= wr_ok && (wr_addr_i == rs1_addr_i); // RULE6
            fwd_b_ff    <= wr_ok && (wr_addr_i == rs2_addr_i); // RULE6
            fwd_c_ff    <= wr_ok && (wr_addr_i == `EP_REG_NUM); // RULE4
            fwd_data_ff <= wr_data_i;
            short_ff    <= short_mem_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs take one more stage so every port is a flip-flop
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rs1_data_o   <= 32'h00000000;
            rs2_data_o   <= 32'h00000000;
            base_addr_o  <= 32'h00000000;
            base_valid_o <= 1'b0;
        end else begin
            rs1_data_o   <= zero_a_ff ? 32'h00000000 : (fwd_a_ff ? fwd_data_ff : arr_a); // RULE2
            rs2_data_o   <= zero_b_ff ? 32'h00000000 : (fwd_b_ff ? fwd_data_ff : arr_b); // RULE2
            base_addr_o  <= fwd_c_ff ? fwd_data_ff : arr_c; // RULE4
            base_valid_o <= short_ff; // RULE4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Only 26 bits kept; carry out of bit 25 dropped, odd targets forced even
    always @* begin
        // Full-width add; bits above 25 are thrown away below
        pc_sum = {6'h00, pc_o[`PC_VALID_MSB:0]} + `PC_STEP; // RULE8
        nxt_pc = pc_o;
        if (pc_load_i) begin
            nxt_pc = {6'h00, pc_target_i[`PC_VALID_MSB:1], 1'b0}; // RULE7
        end else if (pc_advance_i) begin
            nxt_pc = {6'h00, pc_sum[`PC_VALID_MSB:1], 1'b0}; // RULE8
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_o <= `PC_RESET_VALUE;
        end else begin
            pc_o <= nxt_pc; // RULE5
        end
    end

endmodule

// *** common/prog_regs_defines.vh ***
/*
 Constants for the program register file: widths, register numbers,
 program counter valid field and reset values.
 Assumes inclusion by bare name from any design file.
*/
`ifndef PROG_REGS_DEFINES_VH
`define PROG_REGS_DEFINES_VH

`define REG_WIDTH        32
`define REG_COUNT        32
`define REG_ADDR_WIDTH   5
`define ZERO_REG_NUM     5'h00
`define EP_REG_NUM       5'h1E
`define PC_VALID_MSB     25
`define PC_VALID_WIDTH   26
`define PC_STEP          32'h00000002
`define PC_RESET_VALUE   32'h00000000
`define PROG_SPACE_MB    64
`define DATA_SPACE_GB    4
`define PIPE_STAGES      5

`endif

// *** rtl/gpr_array.v ***
/*
 Thirty-two storage words for the general registers, one write port and
 three registered read ports (two operands, one base pointer).
 Assumes the caller filters writes to register zero and masks its reads.
*/
`timescale 1ns/100ps
`include "prog_regs_defines.vh"

module gpr_array (
    input  wire                        clk_i,
    input  wire                        we_i,
    input  wire [`REG_ADDR_WIDTH-1:0]  waddr_i,
    input  wire [`REG_WIDTH-1:0]       wdata_i,
    input  wire [`REG_ADDR_WIDTH-1:0]  raddr_a_i,
    input  wire [`REG_ADDR_WIDTH-1:0]  raddr_b_i,
    input  wire [`REG_ADDR_WIDTH-1:0]  raddr_c_i,
    output reg  [`REG_WIDTH-1:0]       rdata_a_o,
    output reg  [`REG_WIDTH-1:0]       rdata_b_o,
    output reg  [`REG_WIDTH-1:0]       rdata_c_o
);

    reg [`REG_WIDTH-1:0] mem [0:`REG_COUNT-1];

    // No reset on storage; contents undefined until written
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_a_o <= mem[raddr_a_i];
        rdata_b_o <= mem[raddr_b_i];
        rdata_c_o <= mem[raddr_c_i];
    end

endmodule

// *** sim/cpu_program_register_file_asserts.sv ***
/* Port checker for the program register file.
   Assumes a bind from the bench top, one clock, async active-low reset. */
`timescale 1ns/100ps
module cpu_program_register_file_asserts (
    input wire        clk_i, reset_n_i, wr_en_i, short_mem_i, pc_advance_i, pc_load_i,
    input wire        base_valid_o,
    input wire [4:0]  rs1_addr_i, rs2_addr_i, wr_addr_i,
    input wire [31:0] wr_data_i, pc_target_i, rs1_data_o, rs2_data_o, base_addr_o, pc_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Counter keeps 26 bits, even only
    localparam logic [31:0] PCM = 32'h03FFFFFE;
    ////////////////////////////////////////////////////////////////////////
    chk_zero_read: assert property (rs1_addr_i == 5'h00 |-> ##2 rs1_data_o == 32'h0)
        else $error("zero read not zero");
    chk_zero_write: assert property (wr_en_i && wr_addr_i == 5'h00
        && rs2_addr_i == 5'h00 |-> ##2 rs2_data_o == 32'h0) else $error("zero write kept");
    chk_write_fwd: assert property (wr_en_i && wr_addr_i != 5'h00
        && rs1_addr_i == wr_addr_i |-> ##2 rs1_data_o == $past(wr_data_i, 2))
        else $error("write not seen");
    chk_ep_base: assert property (wr_en_i && wr_addr_i == 5'h1E
        |-> ##2 base_addr_o == $past(wr_data_i, 2)) else $error("base not updated");
    chk_base_valid: assert property (1'b1 |-> ##2 base_valid_o == $past(short_mem_i, 2))
        else $error("base valid wrong");
    chk_pc_fixed: assert property (pc_o[31:26] == 6'h00 && !pc_o[0])
        else $error("counter fixed bits set");
    chk_pc_load: assert property (pc_load_i |=> pc_o == ($past(pc_target_i) & PCM))
        else $error("counter load wrong");
    chk_pc_step: assert property (!pc_load_i && pc_advance_i
        |=> pc_o == (($past(pc_o) + 32'h2) & PCM)) else $error("counter step wrong");
    cover property (short_mem_i ##2 base_valid_o);
    cover property (pc_load_i ##1 pc_advance_i);
    cover property (wr_en_i && wr_addr_i == 5'h00);
endmodule

// *** sim/pipe_model.sv ***
/* Pipeline model: drives operand reads, result writes, base and counter
   requests, and notes expected read results. Assumes one design behind it. */
`timescale 1ns/100ps
module pipe_model (
    input  wire         clk_i, reset_n_i,
    output logic [4:0]  rs1_addr_i, rs2_addr_i, wr_addr_i,
    output logic        wr_en_i, short_mem_i, pc_advance_i, pc_load_i,
    output logic [31:0] wr_data_i, pc_target_i
);
    logic [31:0] r [32];
    logic [96:0] q [$];
    int          seed = 24, k = 0;
    initial {rs1_addr_i, rs2_addr_i, wr_addr_i, wr_en_i, short_mem_i, pc_advance_i,
        pc_load_i, wr_data_i, pc_target_i} = '0;
    // Same-edge write is forwarded to the read
    function automatic logic [31:0] rd(input logic [4:0] a);
        return (a == 5'h00) ? 32'h0 : (wr_en_i && wr_addr_i == a) ? wr_data_i : r[a];
    endfunction
    always @(posedge clk_i) if (reset_n_i) begin
        q.push_back({short_mem_i, rd(rs1_addr_i), rd(rs2_addr_i), rd(5'h1E)});
        if (wr_en_i && wr_addr_i != 5'h00) r[wr_addr_i] = wr_data_i;
        k++;
        #1;
        // Fill every register first: unwritten ones read unknown
        wr_en_i = (k < 33) || ($random(seed) & 1);
        wr_addr_i = (k < 33) ? k[4:0] - 5'h01 : $random(seed);
        wr_data_i = $random(seed);
        {rs1_addr_i, rs2_addr_i} = (k < 34) ? 10'h000 : $random(seed);
        {short_mem_i, pc_advance_i, pc_load_i} = (k < 34) ? 3'h0 : $random(seed);
        pc_target_i = $random(seed);
    end
endmodule

// *** sim/test_cpu_program_register_file.sv ***
/* Bench top for the program register file: model drives, queue is checked.
   Assumes 100 MHz clock and the checker bound below. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module test_cpu_program_register_file;
    logic        clk_i, reset_n_i = 1'b0;
    int          fails = 0, cmp_count = 0;
    logic [96:0] e;
    logic [31:0] pt, pc_exp = 32'h00000000;
    logic        pl, pa;
    wire  [4:0]  rs1_addr_i, rs2_addr_i, wr_addr_i;
    wire         wr_en_i, short_mem_i, pc_advance_i, pc_load_i, base_valid_o;
    wire  [31:0] wr_data_i, pc_target_i, rs1_data_o, rs2_data_o, base_addr_o, pc_o;
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    pipe_model m (.*);
    cpu_program_register_file DUT (.*);
    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Outputs after an edge answer the addresses of the edge before: two notes stand
    always @(posedge clk_i) begin
        pl = pc_load_i;
        pa = pc_advance_i;
        pt = pc_target_i;
        #2;
        if (reset_n_i) begin
            pc_exp = pl ? (pt & 32'h03FFFFFE) : (pa ? ((pc_exp + 32'h2) & 32'h03FFFFFE) : pc_exp);
            `CHK("pc", pc_exp, pc_o)
        end
        if (m.q.size() > 1) begin
            e = m.q.pop_front();
            `CHK("rs1", e[95:64], rs1_data_o)
            `CHK("rs2", e[63:32], rs2_data_o)
            `CHK("bvalid", e[96], base_valid_o)
            if (e[96]) `CHK("base", e[31:0], base_addr_o)
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        repeat (400) @(posedge clk_i);
        print_verdict;
    end
endmodule
bind cpu_program_register_file cpu_program_register_file_asserts chk (.*);
